// ---- core/timer2_autoreload_capture.v ----
// 16-bit / dual 8-bit auto-reload timer with capture and register port
//
// Functional notes
// - count kept as separate low and high bytes
// - split bit clear gives one 16-bit counter
// - 16-bit wrap reloads pair (clears to zero in capture mode), sets high flag
// - timer irq enable requests on 16-bit overflow
// - low irq enable adds low-byte wrap interrupts
// - split mode: two 8-bit reloading counters (wrap to zero in capture mode)
// - split mode: run gates high byte only
// - per-byte source: system clock or external field
// - rtc and comparator inputs synchronised first
// - split mode: each byte wrap sets flag
// - split irq: high wrap, low too if enabled
// - flags cleared only by software writes
// - capture mode enabled by capture bit
// - capture on comparator rise or rtc/8
// - capture copies count to reload, sets flag
// - low flag set on any low-byte wrap
// - capture enable sits at control bit 4
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "timer2_defs.vh"

module timer2_autoreload_capture #(
   parameter [3:0] SYS_DIV = `SYS_DIV_COUNT,
   parameter [3:0] RTC_DIV = `RTC_DIV_COUNT
) (
   // clock and reset
   input  wire       clk,
   input  wire       arst_n,
   // register port
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr_stb,
   input  wire       rd_stb,
   output reg  [7:0] rdata,
   // external count and capture sources
   input  wire       rtc_clk,
   input  wire       cmp0_out,
   // timer interrupt request
   output reg        irq
);

   // register state
   reg  [7:0]  count_low_r;
   reg  [7:0]  count_high_r;
   reg  [7:0]  reload_low_r;
   reg  [7:0]  reload_high_r;
   reg         high_ovf_flag_r;
   reg         low_ovf_flag_r;
   reg         low_ovf_irq_en_r;
   reg         capture_en_r;
   reg         split_mode_sel_r;
   reg         run_ctl_r;
   reg  [1:0]  ext_clk_sel_r;
   reg         low_clk_sel_r;
   reg         high_clk_sel_r;
   reg         timer_irq_en_r;
   reg  [3:0]  div12_r;
   reg  [3:0]  rtc_div_r;

   // next values
   reg  [7:0]  count_low_nxt;
   reg  [7:0]  count_high_nxt;
   reg  [7:0]  reload_low_nxt;
   reg  [7:0]  reload_high_nxt;
   reg         high_ovf_flag_nxt;
   reg         low_ovf_flag_nxt;
   reg  [7:0]  rdata_nxt;
   reg         lo_wrap;
   reg         hi_wrap;

   wire        rtc_rise;
   wire        cmp_rise;
   wire        div12_tick;
   wire        rtc8_tick;
   wire        lo_tick;
   wire        hi_tick;
   wire        cap_evt;
   wire [15:0] count16;
   wire [15:0] count16_inc;
   wire        wr_ctrl;
   wire [7:0]  ctrl_value;

   // source selection, shared by both bytes
   function src_tick;
      input       sys_sel;
      input [1:0] ext;
      input       t12;
      input       t8;
      input       tc;
      begin
         if (sys_sel) begin
            src_tick = 1'b1;
         end else begin
            case (ext)
               `EXT_DIV12: src_tick = t12;
               `EXT_RTC8:  src_tick = t8;
               `EXT_CMP0:  src_tick = tc;
               default:    src_tick = 1'b0;
            endcase
         end
      end
   endfunction

   edge_sync u_rtc_sync (
      .clk      (clk),
      .arst_n   (arst_n),
      .async_in (rtc_clk),
      .rise     (rtc_rise)
   );

   edge_sync u_cmp_sync (
      .clk      (clk),
      .arst_n   (arst_n),
      .async_in (cmp0_out),
      .rise     (cmp_rise)
   );

   assign div12_tick  = (div12_r == SYS_DIV - 4'h1);
   assign rtc8_tick   = rtc_rise && (rtc_div_r == RTC_DIV - 4'h1);

   assign lo_tick     = src_tick(low_clk_sel_r, ext_clk_sel_r,
                                 div12_tick, rtc8_tick, cmp_rise);
   assign hi_tick     = src_tick(high_clk_sel_r, ext_clk_sel_r,
                                 div12_tick, rtc8_tick, cmp_rise);

   // capture source picked by upper external select bit
   assign cap_evt     = capture_en_r &&
                        (ext_clk_sel_r[1] ? cmp_rise : rtc8_tick);

   assign count16     = {count_high_r, count_low_r};
   assign count16_inc = count16 + 16'h0001;

   assign wr_ctrl     = wr_stb && (addr == `ADDR_TIMER_CTRL);

   assign ctrl_value  = {high_ovf_flag_r, low_ovf_flag_r, low_ovf_irq_en_r,
                         capture_en_r, split_mode_sel_r, run_ctl_r, ext_clk_sel_r};

   // counting, reload, capture and flags
   always @* begin
      count_low_nxt     = count_low_r;
      count_high_nxt    = count_high_r;
      reload_low_nxt    = reload_low_r;
      reload_high_nxt   = reload_high_r;
      lo_wrap           = 1'b0;
      hi_wrap           = 1'b0;
      if (!split_mode_sel_r) begin
         if (run_ctl_r && lo_tick) begin
            if (count_low_r == 8'hFF) begin
               lo_wrap = 1'b1;
            end
            if (count16 == 16'hFFFF) begin
               hi_wrap = 1'b1;
               if (capture_en_r) begin
                  count_low_nxt  = 8'h00;
                  count_high_nxt = 8'h00;
               end else begin
                  count_low_nxt  = reload_low_r;
                  count_high_nxt = reload_high_r;
               end
            end else begin
               count_low_nxt  = count16_inc[7:0];
               count_high_nxt = count16_inc[15:8];
            end
         end
      end else begin
         // low byte runs regardless of run control
         if (lo_tick) begin
            if (count_low_r == 8'hFF) begin
               lo_wrap       = 1'b1;
               count_low_nxt = capture_en_r ? 8'h00 : reload_low_r;
            end else begin
               count_low_nxt = count_low_r + 8'h01;
            end
         end
         if (run_ctl_r && hi_tick) begin
            if (count_high_r == 8'hFF) begin
               hi_wrap        = 1'b1;
               count_high_nxt = capture_en_r ? 8'h00 : reload_high_r;
            end else begin
               count_high_nxt = count_high_r + 8'h01;
            end
         end
      end

      // software writes to the count win over counting
      if (wr_stb && (addr == `ADDR_COUNT_LOW)) begin
         count_low_nxt = wdata;
      end
      if (wr_stb && (addr == `ADDR_COUNT_HIGH)) begin
         count_high_nxt = wdata;
      end

      // capture wins over a software write to reload
      if (wr_stb && (addr == `ADDR_RELOAD_LOW)) begin
         reload_low_nxt = wdata;
      end
      if (wr_stb && (addr == `ADDR_RELOAD_HIGH)) begin
         reload_high_nxt = wdata;
      end
      if (cap_evt) begin
         reload_low_nxt  = count_low_r;
         reload_high_nxt = count_high_r;
      end

      // flags: hardware only sets, set beats a clearing write
      high_ovf_flag_nxt = (wr_ctrl ? wdata[`CTRL_HIGH_OVF] : high_ovf_flag_r)
                          | hi_wrap | cap_evt;
      low_ovf_flag_nxt  = (wr_ctrl ? wdata[`CTRL_LOW_OVF] : low_ovf_flag_r)
                          | lo_wrap;
   end

   // read data, valid the cycle after the strobe
   always @* begin
      rdata_nxt = 8'h00;
      if (rd_stb) begin
         if (addr == `ADDR_TIMER_CTRL) begin
            rdata_nxt = ctrl_value;
         end else if (addr == `ADDR_COUNT_LOW) begin
            rdata_nxt = count_low_r;
         end else if (addr == `ADDR_COUNT_HIGH) begin
            rdata_nxt = count_high_r;
         end else if (addr == `ADDR_RELOAD_LOW) begin
            rdata_nxt = reload_low_r;
         end else if (addr == `ADDR_RELOAD_HIGH) begin
            rdata_nxt = reload_high_r;
         end else if (addr == `ADDR_CLOCK_CTRL) begin
            rdata_nxt = {6'h00, high_clk_sel_r, low_clk_sel_r};
         end else if (addr == `ADDR_IRQ_ENABLE) begin
            rdata_nxt = {2'h0, timer_irq_en_r, 5'h00};
         end else begin
            rdata_nxt = 8'h00;
         end
      end
   end

   // prescalers
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div12_r   <= 4'h0;
         rtc_div_r <= 4'h0;
      end else begin
         div12_r <= div12_tick ? 4'h0 : div12_r + 4'h1;
         if (rtc_rise) begin
            rtc_div_r <= rtc8_tick ? 4'h0 : rtc_div_r + 4'h1;
         end
      end
   end

   // counter, reload and flags
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_low_r     <= `RST_BYTE;
         count_high_r    <= `RST_BYTE;
         reload_low_r    <= `RST_BYTE;
         reload_high_r   <= `RST_BYTE;
         high_ovf_flag_r <= 1'b0;
         low_ovf_flag_r  <= 1'b0;
      end else begin
         count_low_r     <= count_low_nxt;
         count_high_r    <= count_high_nxt;
         reload_low_r    <= reload_low_nxt;
         reload_high_r   <= reload_high_nxt;
         high_ovf_flag_r <= high_ovf_flag_nxt;
         low_ovf_flag_r  <= low_ovf_flag_nxt;
      end
   end

   // configuration registers
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         low_ovf_irq_en_r <= 1'b0;
         capture_en_r     <= 1'b0;
         split_mode_sel_r <= 1'b0;
         run_ctl_r        <= 1'b0;
         ext_clk_sel_r    <= 2'h0;
         low_clk_sel_r    <= 1'b0;
         high_clk_sel_r   <= 1'b0;
         timer_irq_en_r   <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            low_ovf_irq_en_r <= wdata[`CTRL_LOW_IRQ_EN];
            capture_en_r     <= wdata[`CTRL_CAPTURE_EN];
            split_mode_sel_r <= wdata[`CTRL_SPLIT];
            run_ctl_r        <= wdata[`CTRL_RUN];
            ext_clk_sel_r    <= wdata[`CTRL_EXT_HI:`CTRL_EXT_LO];
         end
         if (wr_stb && (addr == `ADDR_CLOCK_CTRL)) begin
            low_clk_sel_r  <= wdata[`CLK_LOW_SEL];
            high_clk_sel_r <= wdata[`CLK_HIGH_SEL];
         end
         if (wr_stb && (addr == `ADDR_IRQ_ENABLE)) begin
            timer_irq_en_r <= wdata[`IRQEN_TIMER];
         end
      end
   end

   // outputs
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 8'h00;
         irq   <= 1'b0;
      end else begin
         rdata <= rdata_nxt;
         // same gate serves both modes
         irq   <= timer_irq_en_r &&
                  (high_ovf_flag_r || (low_ovf_irq_en_r && low_ovf_flag_r));
      end
   end

endmodule

`default_nettype wire

// ---- core/timer2_defs.vh ----
// register map, field positions, reset values and counts of the auto-reload timer
`ifndef TIMER2_DEFS_VH
`define TIMER2_DEFS_VH

// register offsets
`define ADDR_TIMER_CTRL   8'h00
`define ADDR_COUNT_LOW    8'h01
`define ADDR_COUNT_HIGH   8'h02
`define ADDR_RELOAD_LOW   8'h03
`define ADDR_RELOAD_HIGH  8'h04
`define ADDR_CLOCK_CTRL   8'h05
`define ADDR_IRQ_ENABLE   8'h06

// timer_ctrl_reg fields
`define CTRL_HIGH_OVF     7
`define CTRL_LOW_OVF      6
`define CTRL_LOW_IRQ_EN   5
`define CTRL_CAPTURE_EN   4
`define CTRL_SPLIT        3
`define CTRL_RUN          2
`define CTRL_EXT_HI       1
`define CTRL_EXT_LO       0

// clock_ctrl_reg fields
`define CLK_LOW_SEL       0
`define CLK_HIGH_SEL      1

// irq_enable_reg fields
`define IRQEN_TIMER       5

// reset values
`define RST_BYTE          8'h00

// external source codes
`define EXT_DIV12         2'h0
`define EXT_RTC8          2'h1
`define EXT_RESERVED      2'h2
`define EXT_CMP0          2'h3

// divider counts
`define SYS_DIV_COUNT     4'hC
`define RTC_DIV_COUNT     4'h8

`endif

// ---- core/edge_sync.v ----
// two-stage synchroniser with rising-edge pulse
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
   // clock and reset
   input  wire clk,
   input  wire arst_n,
   // asynchronous level in
   input  wire async_in,
   // one-cycle pulse on a rising edge
   output reg  rise
);

   reg meta_r;
   reg sync_r;
   reg prev_r;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
         rise   <= 1'b0;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
         rise   <= sync_r & ~prev_r;
      end
   end

endmodule

`default_nettype wire

// ---- core/placeholder_unused.v ----
// intentionally empty design unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- tb/timer2_chk_sva.sv ----
// port-level assertions for the auto-reload timer
`timescale 1ns/1ps
`default_nettype none
`include "timer2_defs.vh"
module timer2_chk (
   // clock and reset
   input wire logic       clk,
   input wire logic       arst_n,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] rdata,
   // sources and request
   input wire logic       rtc_clk,
   input wire logic       cmp0_out,
   input wire logic       irq
);
   logic [5:0] ctl_r;
   logic [1:0] cks_r;
   logic       ien_r;
   // shadows of software-only bits
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_r <= 6'h00;
         cks_r <= 2'h0;
         ien_r <= 1'b0;
      end else if (wr_stb) begin
         if (addr == `ADDR_TIMER_CTRL) ctl_r <= wdata[5:0];
         if (addr == `ADDR_CLOCK_CTRL) cks_r <= wdata[1:0];
         if (addr == `ADDR_IRQ_ENABLE) ien_r <= wdata[5];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence rd_ctl;
      rd_stb && addr == `ADDR_TIMER_CTRL;
   endsequence
   sequence two_ctl;
      rd_ctl ##1 rd_ctl;
   endsequence
   a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
      else $error("read data not zero outside read cycle");
   a_unmapped_zero: assert property (rd_stb && addr > 8'h06 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_readback: assert property (rd_ctl |=> rdata[5:0] == $past(ctl_r))
      else $error("control bits read back wrong");
   a_clksel_readback: assert property (rd_stb && addr == 8'h05
      |=> rdata[1:0] == $past(cks_r))
      else $error("clock select read back wrong");
   a_irq_gated: assert property (!$past(ien_r) |-> !irq)
      else $error("irq without timer enable");
   a_irq_flags: assert property (rd_ctl ##0 ien_r
      |=> irq == (rdata[7] | rdata[5] & rdata[6]))
      else $error("irq does not match flags");
   a_flags_sticky: assert property (two_ctl |=> (rdata[7] || !$past(rdata[7]))
      && (rdata[6] || !$past(rdata[6])))
      else $error("flag cleared without write");
   a_irq_hold: assert property (irq && !wr_stb && !$past(wr_stb) |=> irq)
      else $error("irq dropped without write");
endmodule
`default_nettype wire

// ---- tb/timer2_autoreload_capture_tb.sv ----
// self-checking bench for the auto-reload timer
`timescale 1ns/1ps
`default_nettype none
module timer2_autoreload_capture_tb;
   logic       clk;
   logic       arst_n;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] rdata;
   logic       rtc_clk;
   logic       cmp0_out;
   logic       irq;
   logic [7:0] d;
   logic [7:0] e;
   int         error_cnt;
   int         num_checks;
   timer2_autoreload_capture DUT (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .rtc_clk(rtc_clk),
      .cmp0_out(cmp0_out), .irq(irq));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task complete_run;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task chk(input string n, input logic [7:0] x, input logic [7:0] g);
      num_checks++;
      if (g !== x) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, x, g);
      end
   endtask
   task idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask
   task edges(input int n, input logic sel);
      repeat (n) begin
         if (sel) rtc_clk <= 1'b1;
         else cmp0_out <= 1'b1;
         idle(3);
         rtc_clk <= 1'b0;
         cmp0_out <= 1'b0;
         idle(3);
      end
   endtask
   task t_mode16;
      rd(8'h00); chk("ctrl reset", 8'h00, d);
      rd(8'h07);
      chk("unmapped", 8'h00, d);
      wr(8'h03, 8'h00); wr(8'h04, 8'hFF); wr(8'h01, 8'hFF); wr(8'h02, 8'hFF);
      wr(8'h05, 8'h01); wr(8'h06, 8'h20);
      rd(8'h05);
      chk("clock_ctrl", 8'h01, d);
      rd(8'h06);
      chk("irq_enable", 8'h20, d);
      wr(8'h00, 8'h04);
      rd(8'h00); chk("ctrl", 8'hC4, d);
      chk("irq", 8'h01, {7'h00, irq});
      rd(8'h02); chk("count_high", 8'hFF, d);
      wr(8'h00, 8'h00);
      rd(8'h01); e = d;
      rd(8'h01); chk("count_low stopped", e, d);
      chk("irq cleared", 8'h00, {7'h00, irq});
   endtask
   task t_split;
      wr(8'h03, 8'h10); wr(8'h01, 8'hFE); wr(8'h02, 8'hFF); wr(8'h00, 8'h08);
      idle(4);
      rd(8'h00); chk("ctrl", 8'h48, d);
      chk("irq", 8'h00, {7'h00, irq});
      rd(8'h02); chk("count_high", 8'hFF, d);
      rd(8'h01); chk("count_low", 8'h01, {7'h00, d >= 8'h10 && d < 8'h20});
      wr(8'h00, 8'h68);
      rd(8'h00); chk("irq", 8'h01, {7'h00, irq});
      @(posedge clk);
      addr <= 8'h00;
      rd_stb <= 1'b1;
      idle(2);
      rd_stb <= 1'b0;
      #1 chk("ctrl low flag", 8'h01, {7'h00, rdata[6]});
      wr(8'h04, 8'h20); wr(8'h05, 8'h03); wr(8'h00, 8'h0C);
      rd(8'h00); chk("high flag", 8'h01, {7'h00, d[7]});
      rd(8'h02); chk("count_high", 8'h01, {7'h00, d >= 8'h20 && d < 8'h40});
   endtask
   task t_source;
      wr(8'h05, 8'h00); wr(8'h00, 8'h06); wr(8'h01, 8'h00);
      idle(20);
      rd(8'h01); chk("reserved", 8'h00, d);
      wr(8'h00, 8'h04); wr(8'h01, 8'h00);
      idle(118);
      rd(8'h01); chk("div12", 8'h01, {7'h00, d >= 8'h09 && d <= 8'h0B});
      wr(8'h00, 8'h07); wr(8'h01, 8'h00); edges(5, 1'b0); idle(4);
      rd(8'h01); chk("cmp count", 8'h05, d);
      wr(8'h00, 8'h05); wr(8'h01, 8'h00); edges(16, 1'b1); idle(4);
      rd(8'h01); chk("rtc count", 8'h02, d);
   endtask
   task t_capture;
      for (int s = 0; s < 2; s++) begin
         wr(8'h05, 8'h01); wr(8'h01, 8'h00); wr(8'h02, 8'h00);
         wr(8'h00, s ? 8'h15 : 8'h17);
         edges(8, s[0]);
         idle(5);
         rd(8'h00); chk("capture flag", 8'h01, {7'h00, d[7]});
         rd(8'h04); chk("capture high", 8'h00, d);
         rd(8'h03); chk("capture low", 8'h01, {7'h00, d >= 8'h20 && d < 8'h48});
      end
      // no capture source edges: overflow must free-run to zero
      wr(8'h04, 8'h55);
      wr(8'h02, 8'hFF);
      wr(8'h01, 8'hF0);
      idle(20);
      rd(8'h02);
      chk("free run high", 8'h00, d);
      rd(8'h00);
      chk("capture wrap flags", 8'hD5, d);
   endtask
   initial begin
      error_cnt = 0;
      num_checks = 0;
      arst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      rtc_clk = 1'b0;
      cmp0_out = 1'b0;
      idle(8);
      arst_n <= 1'b1;
      t_mode16;
      t_split;
      t_source;
      t_capture;
      complete_run;
   end
   initial begin
      idle(20000);
      error_cnt++;
      complete_run;
   end
endmodule
bind timer2_autoreload_capture timer2_chk u_chk (.clk(clk), .arst_n(arst_n), .addr(addr),
   .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .rtc_clk(rtc_clk),
   .cmp0_out(cmp0_out), .irq(irq));
`default_nettype wire
